// File: pssn_pkg.sv
// Purpose: constants and carriers for the power-state I/O snooper
// Assumes: byte-wide configuration access, 16-bit snooped I/O data
// Notes: trigger sets are seven bytes each, port/mask/value/access
package pssn_pkg;
  localparam logic [7:0] CFG_WIN_LO = 8'hd8;
  localparam logic [7:0] CFG_WIN_HI = 8'hf7;
  localparam logic [7:0] SET_POS_BASE = 8'hd8;
  localparam logic [7:0] SET_QS_BASE = 8'he0;
  localparam logic [7:0] SET_DS_BASE = 8'he8;
  localparam logic [7:0] SET_STR_BASE = 8'hf0;
  // byte offsets inside one set
  localparam logic [2:0] FLD_PORT_LO = 3'h0;
  localparam logic [2:0] FLD_PORT_HI = 3'h1;
  localparam logic [2:0] FLD_MASK_LO = 3'h2;
  localparam logic [2:0] FLD_MASK_HI = 3'h3;
  localparam logic [2:0] FLD_VAL_LO = 3'h4;
  localparam logic [2:0] FLD_VAL_HI = 3'h5;
  localparam logic [2:0] FLD_ACC = 3'h6;
  localparam logic [7:0] CFG_POWER_CTL = 8'h7a;
  localparam int PORT_ACCESS_EN_BIT = 6;
  localparam logic [15:0] IO_POWER_CTL_PORT = 16'h0022;
  localparam int ARBITER_DISABLE_BIT = 0;
  localparam logic [1:0] ACC_READ = 2'h1;
  localparam logic [1:0] ACC_WRITE = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;
  localparam logic [15:0] TRIG_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int NUM_ATTR_REGS = 7;
  localparam logic [7:0] ATTR_BASE = 8'h50;
  localparam int NUM_SETS = 4;

  // index order of trigger sets and of request bits
  typedef enum logic [1:0] {
    PS_QUICK_START,
    PS_DEEP_SLEEP,
    PS_RAM_SUSPEND,
    PS_POWERED_SUSPEND
  } pssn_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
  } pssn_io_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pssn_cfg_t;

  typedef struct packed {
    logic [15:0] port;
    logic [15:0] mask;
    logic [15:0] value;
    logic [7:0] access;
  } pssn_trig_t;
endpackage : pssn_pkg

// File: pssn_snooper.sv
// Purpose: power-state trigger snooper for host I/O cycles
// Assumes: config and I/O cycles are one-cycle strobes on clk
// Notes: state lives in always-on flops, so sleep never loses it
// Summary of operation
// - configuration state other than the attribute bytes survives sleep and suspend
// - suspend-to-RAM resets seven memory attribute registers
// - trigger registers decoded at config D8-F7h
// - quick start set at E0-E6h
// - deep sleep set at E8-EEh
// - suspend-to-RAM set at F0-F6h
// - powered suspend set at D8-DEh
// - address must match exactly
// - compare only data bits where mask set
// - masked data equals masked expected value
// - access select zero disables snooper
// - 01h reads only, 02h writes only
// - port 22h bit 0 disables bus arbiter
// - self refresh internal, only with clocks stopped
`timescale 1ns/1ps
module pssn_snooper
  import pssn_pkg::*;
#(
  parameter int NumSets = NUM_SETS,
  parameter int NumAttrRegs = NUM_ATTR_REGS
)
(
  input wire logic clk,
  input wire logic reset,
  input wire pssn_cfg_t cfgReq,
  input wire pssn_io_t ioCycle,
  input wire logic memClocksStopped,
  output logic [7:0] cfgRdata,
  output logic cfgHit,
  output logic [NumSets-1:0] transitionReq,
  output logic arbiterDisable,
  output logic selfRefresh,
  output logic [8*NumAttrRegs-1:0] memoryAttributeRegs
);
  // self refresh tracking; rearmed means a new request came mid-refresh
  typedef enum logic [1:0] {
    SR_IDLE,
    SR_ARMED,
    SR_REFRESH,
    SR_REARMED
  } pssn_refresh_t;

  // fields pack per set in byte order: port, mask, value, access
  logic [NumSets-1:0] setSel;
  logic [7:0] setRd [NumSets];
  logic [7:0] powerCtlCfg_reg, powerCtlCfg_next;
  logic [7:0] attr_reg [NumAttrRegs];
  logic [7:0] attr_next [NumAttrRegs];
  logic arbDis_reg, arbDis_next;
  logic selfRef_reg, selfRef_next;
  pssn_refresh_t refresh_reg, refresh_next;
  logic [NumSets-1:0] req_reg, req_next;
  logic [NumSets-1:0] match;
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic portAccessEn;
  logic ioPortHit;
  logic deepMatch;

  // each set has a fixed base and request bit, so the count is fixed
  if (NumSets != NUM_SETS) begin : g_bad_sets
    $error("trigger set count must be four");
  end
  // more bytes would run past the attribute block
  if (NumAttrRegs < 1 || NumAttrRegs > 8) begin : g_bad_attr
    $error("attribute register count out of range");
  end

  assign portAccessEn = powerCtlCfg_reg[PORT_ACCESS_EN_BIT];
  assign ioPortHit = ioCycle.valid && portAccessEn &&
                     (ioCycle.addr == IO_POWER_CTL_PORT);

  function automatic logic [7:0] setBase(input int idx);
    case (idx)
      0: setBase = SET_QS_BASE;
      1: setBase = SET_DS_BASE;
      2: setBase = SET_STR_BASE;
      default: setBase = SET_POS_BASE;
    endcase
  endfunction : setBase

  // per-set decode, registers and comparator
  for (genvar s = 0; s < NumSets; s++) begin : g_set
    pssn_trig_t trig_reg, trig_next;
    logic [7:0] off;
    logic [2:0] fld;
    logic sel;
    logic [7:0] rd;
    logic accOk;
    logic [1:0] acc;

    assign off = cfgReq.addr - setBase(s);
    assign fld = off[2:0];
    // eighth byte of each set is a gap, never a field
    assign sel = cfgReq.valid && off[7:3] == 5'h00 && fld <= FLD_ACC;
    assign setSel[s] = sel;
    assign setRd[s] = rd;

    always_comb begin
      trig_next = trig_reg;
      case (fld)
        FLD_PORT_LO: rd = trig_reg.port[7:0];
        FLD_PORT_HI: rd = trig_reg.port[15:8];
        FLD_MASK_LO: rd = trig_reg.mask[7:0];
        FLD_MASK_HI: rd = trig_reg.mask[15:8];
        FLD_VAL_LO: rd = trig_reg.value[7:0];
        FLD_VAL_HI: rd = trig_reg.value[15:8];
        FLD_ACC: rd = trig_reg.access;
        default: rd = BYTE_RESET;
      endcase
      if (sel && cfgReq.write) begin
        case (fld)
          FLD_PORT_LO: trig_next.port[7:0] = cfgReq.wdata;
          FLD_PORT_HI: trig_next.port[15:8] = cfgReq.wdata;
          FLD_MASK_LO: trig_next.mask[7:0] = cfgReq.wdata;
          FLD_MASK_HI: trig_next.mask[15:8] = cfgReq.wdata;
          FLD_VAL_LO: trig_next.value[7:0] = cfgReq.wdata;
          FLD_VAL_HI: trig_next.value[15:8] = cfgReq.wdata;
          FLD_ACC: trig_next.access = cfgReq.wdata;
          default: trig_next = trig_reg;
        endcase
      end
    end

    // only reset clears the set; sleep leaves it alone
    always_ff @(posedge clk) begin
      if (reset) begin
        trig_reg <= '{TRIG_RESET, TRIG_RESET, TRIG_RESET, BYTE_RESET};
      end else begin
        trig_reg <= trig_next;
      end
    end

    // upper access bits are ignored
    assign acc = trig_reg.access[1:0];
    always_comb begin
      case (acc)
        ACC_READ: accOk = !ioCycle.write;
        ACC_WRITE: accOk = ioCycle.write;
        ACC_BOTH: accOk = 1'b1;
        default: accOk = 1'b0;
      endcase
    end
    assign match[s] = ioCycle.valid && accOk &&
        (ioCycle.addr == trig_reg.port) &&
        ((ioCycle.data & trig_reg.mask) ==
         (trig_reg.value & trig_reg.mask));
  end

  // config readback, power control byte and attribute bytes
  always_comb begin
    for (int a = 0; a < NumAttrRegs; a++) attr_next[a] = attr_reg[a];
    powerCtlCfg_next = powerCtlCfg_reg;
    rdata_next = BYTE_RESET;
    hit_next = 1'b0;
    if (cfgReq.valid && cfgReq.addr == CFG_POWER_CTL) begin
      hit_next = 1'b1;
      if (cfgReq.write) powerCtlCfg_next = cfgReq.wdata;
      else rdata_next = powerCtlCfg_reg;
    end
    for (int a = 0; a < NumAttrRegs; a++) begin
      if (cfgReq.valid && cfgReq.addr == ATTR_BASE + 8'(a)) begin
        hit_next = 1'b1;
        if (cfgReq.write) attr_next[a] = cfgReq.wdata;
        else rdata_next = attr_reg[a];
      end
    end
    // gaps inside D8-F7h claim the cycle and read as zero
    if (cfgReq.valid && cfgReq.addr >= CFG_WIN_LO &&
        cfgReq.addr <= CFG_WIN_HI) begin
      hit_next = 1'b1;
    end
    // writes answer zero so a stale field never leaks out
    for (int s = 0; s < NumSets; s++) begin
      if (setSel[s]) begin
        hit_next = 1'b1;
        rdata_next = cfgReq.write ? BYTE_RESET : setRd[s];
      end
    end
    // attribute clear lands after any same-cycle write
    if (match[PS_RAM_SUSPEND]) begin
      for (int a = 0; a < NumAttrRegs; a++) begin
        attr_next[a] = BYTE_RESET;
      end
    end
  end

  // reset clears these flops, a suspend-to-RAM match also clears the attribute bytes; sleep leaves them alone
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int a = 0; a < NumAttrRegs; a++) attr_reg[a] <= BYTE_RESET;
      powerCtlCfg_reg <= BYTE_RESET;
      rdata_reg <= BYTE_RESET;
      hit_reg <= 1'b0;
    end else begin
      attr_reg <= attr_next;
      powerCtlCfg_reg <= powerCtlCfg_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  // request pulses and the arbiter bit
  always_comb begin
    req_next = match;
    arbDis_next = arbDis_reg;
    if (ioPortHit && ioCycle.write) begin
      arbDis_next = ioCycle.data[ARBITER_DISABLE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      req_reg <= '0;
      arbDis_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      arbDis_reg <= arbDis_next;
    end
  end

  // any state deeper than quick start may stop the memory clocks
  assign deepMatch = match[PS_RAM_SUSPEND] || match[PS_DEEP_SLEEP] ||
                     match[PS_POWERED_SUSPEND];

  // entry stays armed until the memory clocks really stop
  always_comb begin
    refresh_next = refresh_reg;
    case (refresh_reg)
      SR_IDLE: begin
        if (deepMatch) refresh_next = SR_ARMED;
      end
      SR_ARMED: begin
        if (memClocksStopped) refresh_next = SR_REFRESH;
      end
      SR_REFRESH: begin
        if (!memClocksStopped) begin
          refresh_next = deepMatch ? SR_ARMED : SR_IDLE;
        end else if (deepMatch) begin
          refresh_next = SR_REARMED;
        end
      end
      SR_REARMED: begin
        if (!memClocksStopped) refresh_next = SR_ARMED;
      end
      default: refresh_next = SR_IDLE;
    endcase
    selfRef_next = (refresh_next == SR_REFRESH) ||
                   (refresh_next == SR_REARMED);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      refresh_reg <= SR_IDLE;
      selfRef_reg <= 1'b0;
    end else begin
      refresh_reg <= refresh_next;
      selfRef_reg <= selfRef_next;
    end
  end

  for (genvar a = 0; a < NumAttrRegs; a++) begin : g_attr
    assign memoryAttributeRegs[8*a +: 8] = attr_reg[a];
  end

  assign cfgRdata = rdata_reg;
  assign cfgHit = hit_reg;
  assign transitionReq = req_reg;
  assign arbiterDisable = arbDis_reg;
  assign selfRefresh = selfRef_reg;
endmodule : pssn_snooper

// File: pssn_snooper_sva.sv
// Purpose: port-level checks for the power-state snooper
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every snooper instance
`timescale 1ns/1ps
module pssn_snooper_sva
  import pssn_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire pssn_cfg_t cfgReq,
  input wire pssn_io_t ioCycle,
  input wire logic memClocksStopped,
  input wire logic [7:0] cfgRdata,
  input wire logic cfgHit,
  input wire logic [NUM_SETS-1:0] transitionReq,
  input wire logic arbiterDisable,
  input wire logic selfRefresh,
  input wire logic [8*NUM_ATTR_REGS-1:0] memoryAttributeRegs
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence gapRead;
    cfgReq.valid && !cfgReq.write && cfgReq.addr == CFG_WIN_HI;
  endsequence
  sequence clocksDrop;
    $fell(memClocksStopped);
  endsequence
  a_window_hit:
    assert property (cfgReq.valid && cfgReq.addr >= CFG_WIN_LO &&
      cfgReq.addr <= CFG_WIN_HI |=> cfgHit) else $error("window miss");
  a_idle_quiet:
    assert property (!cfgReq.valid |=> !cfgHit) else $error("stray hit");
  a_gap_zero:
    assert property (gapRead |=> cfgHit && cfgRdata == 8'h00)
      else $error("gap read nonzero");
  a_req_cause:
    assert property (|transitionReq |-> $past(ioCycle.valid))
      else $error("request without cycle");
  a_req_quiet:
    assert property (!ioCycle.valid |=> transitionReq == 4'h0)
      else $error("request while idle");
  a_attr_clear:
    assert property (transitionReq[PS_RAM_SUSPEND] |-> memoryAttributeRegs
      == '0) else $error("attributes kept");
  a_attr_hold:
    assert property ($changed(memoryAttributeRegs) |-> $past(cfgReq.valid
      && cfgReq.write || ioCycle.valid)) else $error("attributes drift");
  a_arb_cause:
    assert property ($changed(arbiterDisable) |-> $past(ioCycle.valid &&
      ioCycle.write && ioCycle.addr == IO_POWER_CTL_PORT))
      else $error("arbiter moved alone");
  a_refresh_gate:
    assert property ($rose(selfRefresh) |-> $past(memClocksStopped))
      else $error("refresh with clocks");
  a_refresh_drop:
    assert property (clocksDrop |=> !selfRefresh)
      else $error("refresh held");
endmodule : pssn_snooper_sva
bind pssn_snooper pssn_snooper_sva chk_u (.clk, .reset, .cfgReq, .ioCycle,
  .memClocksStopped, .cfgRdata, .cfgHit, .transitionReq, .arbiterDisable,
  .selfRefresh, .memoryAttributeRegs);

// File: pssn_io_host.sv
// Purpose: host issuing I/O cycles toward southbridge ports
// Assumes: one cycle per clock while go is high
// Notes: idle fields scrambled so stale values never look valid
`timescale 1ns/1ps
module pssn_io_host
  import pssn_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [15:0] data,
  output pssn_io_t ioCycle
);
  logic [31:0] scramble_reg = 32'h0;
  always @(posedge clk) scramble_reg <= scramble_reg + 32'h9e3779b9;
  // port passed through exactly as software issues it
  assign ioCycle = go ? {1'b1, wr, addr, data} :
    {1'b0, scramble_reg[0], scramble_reg};
endmodule : pssn_io_host

// File: power_state_io_snooper_test.sv
// Purpose: self-checking bench for the power-state snooper
// Assumes: fixed seed, four sets with distinct ports
// Notes: results matched in order through two queues
`timescale 1ns/1ps
module power_state_io_snooper_test;
  import pssn_pkg::*;
  logic clk = 0, reset = 1, memClocksStopped = 0, go = 0, wr = 0;
  logic [15:0] ioAddr = 0, ioData = 0, d;
  logic [3:0] e, transitionReq;
  logic [7:0] cfgRdata, cq[$];
  logic [3:0] tq[$];
  logic cfgHit, arbiterDisable, selfRefresh;
  logic [55:0] memoryAttributeRegs, attr;
  pssn_cfg_t cfgReq = '0;
  pssn_io_t ioCycle;
  pssn_trig_t trig[4];
  logic [7:0] base[4] = '{SET_QS_BASE, SET_DS_BASE, SET_STR_BASE,
    SET_POS_BASE};
  int fails = 0, totalChecks = 0;
  always #2 clk = ~clk;
  pssn_io_host host_u (.clk, .go, .wr, .addr(ioAddr), .data(ioData),
    .ioCycle);
  pssn_snooper dut_u (.clk, .reset, .cfgReq, .ioCycle, .memClocksStopped,
    .cfgRdata, .cfgHit, .transitionReq, .arbiterDisable, .selfRefresh,
    .memoryAttributeRegs);
  task automatic chk(input logic [55:0] got, exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (fails == 0 && totalChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // reads pass the expected byte as dt; hit says an answer is due
  task automatic cfg(input logic w, input logic [7:0] a, dt,
      input logic hit);
    go <= 1'b0;
    cfgReq <= '{1'b1, w, a, dt};
    if (hit) cq.push_back(w ? 8'h00 : dt);
    @(posedge clk);
  endtask : cfg
  task automatic io(input logic w, input logic [15:0] a, dt,
      input logic [3:0] ex);
    cfgReq.valid <= 1'b0;
    go <= 1'b1;
    wr <= w;
    ioAddr <= a;
    ioData <= dt;
    if (ex != 0) tq.push_back(ex);
    @(posedge clk);
  endtask : io
  task automatic idle(input int n);
    cfgReq.valid <= 1'b0;
    go <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic setw(input int s, input logic wrt);
    logic [55:0] sb;
    sb = {trig[s].access, trig[s].value, trig[s].mask, trig[s].port};
    for (int b = 0; b < 7; b++)
      if (wrt) cfg(1, base[s] + 8'(b), sb[8*b+:8], 1);
    for (int b = 0; b < 7; b++) cfg(0, base[s] + 8'(b), sb[8*b+:8], 1);
  endtask : setw
  always @(negedge clk) begin
    if (cfgHit) chk(cfgRdata, cq.size() ? cq.pop_front() : 56'hbad);
    if (|transitionReq)
      chk(transitionReq, tq.size() ? tq.pop_front() : 56'hbad);
  end
  initial begin
    #40000;
    fails++;
    conclude;
  end
  initial begin
    void'($urandom(32'h53f7));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    memClocksStopped <= 1'b1;
    idle(3);
    chk(selfRefresh, 0);
    memClocksStopped <= 1'b0;
    io(1, IO_POWER_CTL_PORT, 16'h0001, 0);
    idle(2);
    chk(arbiterDisable, 0);
    cfg(1, CFG_POWER_CTL, 8'h40, 1);
    io(1, IO_POWER_CTL_PORT, 16'h0001, 0);
    io(0, IO_POWER_CTL_PORT, 16'h0000, 0);
    idle(2);
    chk(arbiterDisable, 1);
    cfg(1, 8'hf7, 8'h5a, 1);
    cfg(0, 8'hf7, 8'h00, 1);
    cfg(0, 8'h10, 8'h00, 0);
    attr = 56'({$urandom, $urandom});
    for (int i = 0; i < 7; i++) cfg(1, ATTR_BASE + 8'(i), attr[8*i+:8], 1);
    idle(2);
    chk(memoryAttributeRegs, attr);
    for (int s = 0; s < 4; s++) begin
      trig[s] = {2'(s), 1'b1, 13'($urandom), 16'($urandom) | 16'h1,
        16'($urandom), 8'h00};
      for (int m = 0; m < 4; m++) begin
        trig[s].access = 8'(m);
        setw(s, 1);
        for (int w = 0; w < 2; w++) begin
          d = (trig[s].value & trig[s].mask) | (16'($urandom) & ~trig[s].mask);
          e = m[w] ? 4'(1 << s) : 4'h0;
          io(w[0], trig[s].port, d, e);
          io(w[0], trig[s].port ^ 16'h1, d, 0);
          io(w[0], trig[s].port, d ^ (trig[s].mask & -trig[s].mask), 0);
        end
      end
    end
    idle(2);
    chk(memoryAttributeRegs, 0);
    setw(0, 0);
    memClocksStopped <= 1'b1;
    idle(3);
    chk(selfRefresh, 1);
    memClocksStopped <= 1'b0;
    idle(3);
    chk(selfRefresh, 0);
    chk(cq.size() + tq.size(), 0);
    conclude;
  end
endmodule : power_state_io_snooper_test
